// ===== src/mia_ctrl.sv
`timescale 1ns/100ps
module mia_ctrl #(
  parameter int N_SRC = 8   // number of interrupt sources
) (
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // core side
  input  wire logic                      instr_boundary, // an instruction starts
  input  wire logic                      accept_ack,     // core jumped to vector
  output logic                           int_pending,    // acceptance request
  output logic      [$clog2(N_SRC)-1:0]  int_source,     // chosen source
  output logic      [2:0]                int_level,      // its level
  // peripheral side
  input  wire logic [N_SRC-1:0]          src_event       // one-cycle events
);

  localparam int IW = $clog2(N_SRC);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (N_SRC < 2 || N_SRC > 16) begin : g_bad_n
    $error("mia_ctrl: N_SRC must be 2..16");
  end

  // ----------------------------------------------------------------
  // state of this module
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             gate_arch;  // architectural gate flag
    logic             gate_eff;   // gate seen by acceptance
    logic [N_SRC-1:0] req;        // request bits
    logic [N_SRC-1:0] [2:0] lvl;  // software-visible levels
    logic [2:0]       thr;        // software-visible threshold
    logic             pend;       // latched acceptance
    logic [IW-1:0]    src;        // latched winner
    logic [2:0]       plvl;       // latched winner level
    logic [31:0]      rdata;      // read data
  } mia_st_t;

  mia_st_t st;       // registered state
  mia_st_t next_st;  // next state

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  mia_pkg::mia_apb_req_t bus;     // bundled request
  logic                  wr_en;   // write in access phase
  logic                  rd_en;   // read in setup phase
  logic                  is_ctrl; // address falls in control block
  logic [IW-1:0]         ctrl_ix; // addressed source
  logic                  mapped;  // address is decoded
  mia_pkg::mia_op_t      op;      // instruction code written

  assign bus     = '{psel: psel, penable: penable, pwrite: pwrite,
                     paddr: paddr, pwdata: pwdata};
  assign wr_en   = bus.psel && bus.penable && bus.pwrite;
  assign rd_en   = bus.psel && !bus.penable && !bus.pwrite;
  assign is_ctrl = (bus.paddr >= mia_pkg::ADDR_CTRL0) &&
                   (bus.paddr < mia_pkg::ADDR_CTRL0 + 12'(N_SRC * mia_pkg::CTRL_STRIDE));
  assign ctrl_ix = IW'((bus.paddr - mia_pkg::ADDR_CTRL0) >> 2);
  assign mapped  = (bus.paddr[1:0] == 2'h0) &&
                   (is_ctrl || bus.paddr == mia_pkg::ADDR_FLAG ||
                    bus.paddr == mia_pkg::ADDR_INSTR ||
                    bus.paddr == mia_pkg::ADDR_STATUS);
  assign op      = mia_pkg::mia_op_t'(bus.pwdata[mia_pkg::OP_LSB +: 3]);

  // the slave answers in the first access cycle, always
  assign pready  = 1'b1;
  // unmapped address answers with an error, data zero
  assign pslverr = bus.psel && bus.penable && !mapped;

  // ----------------------------------------------------------------
  // instruction decode: each write to the instruction port is one
  // flag-changing instruction whose final cycle is this edge
  // ----------------------------------------------------------------
  logic       ins_wr;     // instruction executed
  logic [2:0] ins_thr;    // new threshold carried with it
  logic       ins_gate;   // new gate carried with it
  logic       thr_load;   // threshold change started
  logic [1:0] thr_dly;    // its latency
  logic       lvl_wr;     // a control register write
  logic [N_SRC-1:0] lvl_load; // per-source level change

  assign ins_wr   = wr_en && mapped && bus.paddr == mia_pkg::ADDR_INSTR;
  assign ins_thr  = bus.pwdata[mia_pkg::THR_LSB +: mia_pkg::LVL_W];
  assign ins_gate = bus.pwdata[mia_pkg::GATE_BIT];
  assign lvl_wr   = wr_en && mapped && is_ctrl;

  // threshold latency chosen by the changing instruction
  always_comb begin
    thr_load = 1'b0;
    thr_dly  = mia_pkg::DLY_THR_LOAD;
    case (op)
      mia_pkg::OP_RETURN: begin
        thr_load = ins_wr;
        thr_dly  = mia_pkg::DLY_THR_RET;
      end
      mia_pkg::OP_POP_CTRL, mia_pkg::OP_LOAD_CTRL, mia_pkg::OP_LOAD_THR: begin
        thr_load = ins_wr;
        thr_dly  = mia_pkg::DLY_THR_LOAD;
      end
      default: begin
        // clear and set leave the threshold alone
        thr_load = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // delayed threshold and per-source levels
  // ----------------------------------------------------------------
  logic [2:0]             thr_eff;  // threshold used by acceptance
  logic [N_SRC-1:0] [2:0] lvl_eff;  // levels used by acceptance

  mia_delay #(.RST_VAL(mia_pkg::THR_RST)) u_thr (
    .clock   (clock),
    .rst_n   (rst_n),
    .load    (thr_load),
    .delay   (thr_dly),
    .new_val (ins_thr),
    .eff_val (thr_eff)
  );

  for (genvar i = 0; i < N_SRC; i++) begin : g_lvl
    assign lvl_load[i] = lvl_wr && (ctrl_ix == IW'(i));
    mia_delay #(.RST_VAL(mia_pkg::LVL_RST)) u_lvl (
      .clock   (clock),
      .rst_n   (rst_n),
      .load    (lvl_load[i]),
      .delay   (mia_pkg::DLY_LVL),
      .new_val (bus.pwdata[mia_pkg::LVL_LSB +: mia_pkg::LVL_W]),
      .eff_val (lvl_eff[i])
    );
  end

  // ----------------------------------------------------------------
  // acceptance and priority resolution
  // ----------------------------------------------------------------
  logic          gate_now;  // gate governing this cycle
  logic          win_ok;    // some source qualifies
  logic [IW-1:0] win_ix;    // winning source
  logic [2:0]    win_lvl;   // its level

  // a return changes the gate for its own execution; others wait
  assign gate_now = (ins_wr && op == mia_pkg::OP_RETURN) ? ins_gate
                                                         : st.gate_eff;

  always_comb begin
    win_ok  = 1'b0;
    win_ix  = '0;
    win_lvl = 3'h0;
    // candidates are scanned low index first
    // strict compare keeps the lowest index on a tie
    for (int i = 0; i < N_SRC; i++) begin
      if (st.req[i] && lvl_eff[i] > thr_eff && lvl_eff[i] > win_lvl) begin
        win_ok  = 1'b1;
        win_ix  = IW'(i);
        win_lvl = lvl_eff[i];
      end
    end
    win_ok = win_ok && gate_now;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;

    // gate flag: architectural copy now, acceptance copy later except on a return
    if (ins_wr) begin
      case (op)
        mia_pkg::OP_FLAG_CLEAR: next_st.gate_arch = 1'b0;
        mia_pkg::OP_FLAG_SET:   next_st.gate_arch = 1'b1;
        mia_pkg::OP_RETURN, mia_pkg::OP_POP_CTRL, mia_pkg::OP_LOAD_CTRL: begin
          next_st.gate_arch = ins_gate;
        end
        default: next_st.gate_arch = st.gate_arch;
      endcase
      // a return also reaches acceptance at once
      if (op == mia_pkg::OP_RETURN) begin
        next_st.gate_eff = ins_gate;
      end
    end
    // other changers reach acceptance at the next instruction
    if (instr_boundary && !(ins_wr && op == mia_pkg::OP_RETURN)) begin
      next_st.gate_eff = st.gate_arch;
    end
    // software view of the threshold changes at once;
    // acceptance sees it only through the delay pipe
    if (thr_load) begin
      next_st.thr = ins_thr;
    end

    // acceptance sampled at an instruction boundary
    if (st.pend && accept_ack) begin
      next_st.pend = 1'b0;
    end
    if (instr_boundary && !st.pend) begin
      next_st.pend = win_ok;
      next_st.src  = win_ix;
      next_st.plvl = win_lvl;
    end

    // request bits: software clears, vector jump clears, events set
    for (int i = 0; i < N_SRC; i++) begin
      if (lvl_load[i]) begin
        next_st.lvl[i] = bus.pwdata[mia_pkg::LVL_LSB +: mia_pkg::LVL_W];
        // a written one is ignored: software may only clear
        if (!bus.pwdata[mia_pkg::REQ_BIT]) begin
          next_st.req[i] = 1'b0;
        end
      end
      // cleared only once the core has taken the vector
      if (st.pend && accept_ack && st.src == IW'(i)) begin
        next_st.req[i] = 1'b0;
      end
      // set wins over any clear in the same cycle
      if (src_event[i]) begin
        next_st.req[i] = 1'b1;
      end
    end

    // read data captured in the setup cycle
    // zero outside a read keeps write cycles clean
    next_st.rdata = 32'h0;
    if (rd_en) begin
      if (bus.paddr == mia_pkg::ADDR_FLAG) begin
        next_st.rdata[mia_pkg::GATE_BIT] = st.gate_arch;
        next_st.rdata[mia_pkg::THR_LSB +: mia_pkg::LVL_W] = st.thr;
      end else if (bus.paddr == mia_pkg::ADDR_STATUS) begin
        next_st.rdata[0]     = st.pend;
        next_st.rdata[1]     = st.gate_eff;
        next_st.rdata[6:4]   = thr_eff;
        next_st.rdata[10:8]  = st.plvl;
        next_st.rdata[IW+15:16] = st.src;
      end else if (is_ctrl && bus.paddr[1:0] == 2'h0) begin
        next_st.rdata[mia_pkg::LVL_LSB +: mia_pkg::LVL_W] = st.lvl[ctrl_ix];
        next_st.rdata[mia_pkg::REQ_BIT] = st.req[ctrl_ix];
      end
    end
  end

  // ----------------------------------------------------------------
  // register; every field stored on its own
  // reset loads constants only, never another flop
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st.gate_arch <= mia_pkg::GATE_RST;
      st.gate_eff  <= mia_pkg::GATE_RST;
      st.req       <= '0;
      st.lvl       <= '0;
      st.thr       <= mia_pkg::THR_RST;
      st.pend      <= 1'b0;
      st.src       <= '0;
      st.plvl      <= 3'h0;
      st.rdata     <= 32'h0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata      = st.rdata;
  assign int_pending = st.pend;
  assign int_source  = st.src;
  assign int_level   = st.plvl;

endmodule : mia_ctrl

// ===== src/mia_pkg.sv
package mia_pkg;

  // ----------------------------------------------------------------
  // apb register map (one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_FLAG     = 12'h000; // processor_flag_register image
  localparam logic [11:0] ADDR_INSTR    = 12'h004; // instruction strobe port
  localparam logic [11:0] ADDR_STATUS   = 12'h008; // acceptance status
  localparam logic [11:0] ADDR_CTRL0    = 12'h040; // first source control register
  localparam int          CTRL_STRIDE   = 4;       // bytes per control register

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int GATE_BIT   = 6;  // gate flag bit in the flag image
  localparam int THR_LSB    = 12; // threshold field in the flag image
  localparam int LVL_LSB    = 0;  // priority level field in a control reg
  localparam int REQ_BIT    = 3;  // request bit in a control reg
  localparam int LVL_W      = 3;  // level / threshold width
  localparam int OP_LSB     = 8;  // opcode field in the instruction write

  // ----------------------------------------------------------------
  // reset values and timing counts (cycles after the final cycle)
  // ----------------------------------------------------------------
  localparam logic          GATE_RST      = 1'b0;
  localparam logic [2:0]    THR_RST       = 3'h0;
  localparam logic [2:0]    LVL_RST       = 3'h0;
  localparam logic [1:0]    DLY_THR_RET   = 2'h2; // threshold via return
  localparam logic [1:0]    DLY_THR_LOAD  = 2'h3; // threshold via pop/load
  localparam logic [1:0]    DLY_LVL       = 2'h2; // source level via data move

  // ----------------------------------------------------------------
  // instruction codes presented by the core
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE        = 3'h0,
    OP_RETURN      = 3'h1, // return_from_interrupt_instr
    OP_FLAG_CLEAR  = 3'h2, // flag_clear_instr
    OP_FLAG_SET    = 3'h3, // flag_set_instr
    OP_POP_CTRL    = 3'h4, // pop_control_reg_instr
    OP_LOAD_CTRL   = 3'h5, // load_control_reg_instr
    OP_LOAD_THR    = 3'h6  // load_threshold_instr
  } mia_op_t;

  // apb request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mia_apb_req_t;

  // delayed-update pipe for one 3-bit value
  typedef struct packed {
    logic       busy;  // an update is in flight
    logic [1:0] cnt;   // cycles left
    logic [2:0] val;   // value to commit
  } mia_dly_t;

endpackage : mia_pkg

// ===== src/mia_delay.sv
`timescale 1ns/100ps
// holds a 3-bit value and commits a new one a set number of cycles later
module mia_delay #(
  parameter logic [2:0] RST_VAL = 3'h0
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       load,      // start a delayed update
  input  wire logic [1:0] delay,     // cycles before commit, at least 1
  input  wire logic [2:0] new_val,   // value to commit
  output logic      [2:0] eff_val    // value the acceptance logic sees
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    mia_pkg::mia_dly_t p;   // pending update
    logic [2:0]        e;   // effective value
  } mia_delay_st_t;

  mia_delay_st_t st;        // registered state
  mia_delay_st_t next_st;   // next state

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (st.p.busy) begin
      if (st.p.cnt == 2'h1) begin
        next_st.e      = st.p.val;
        next_st.p.busy = 1'b0;
      end else begin
        next_st.p.cnt = st.p.cnt - 2'h1;
      end
    end
    // a newer write overrides one in flight; last writer wins
    if (load) begin
      next_st.p.busy = 1'b1;
      next_st.p.cnt  = (delay == 2'h0) ? 2'h1 : delay;
      next_st.p.val  = new_val;
    end
  end

  // ----------------------------------------------------------------
  // register
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '{p: '{busy: 1'b0, cnt: 2'h0, val: RST_VAL}, e: RST_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign eff_val = st.e;

endmodule : mia_delay

// ===== sim/mia_ctrl_sva.sv
`timescale 1ns/100ps
// ----------------------------------------
// port checker for the acceptance block
// ----------------------------------------
module mia_ctrl_sva #(
  parameter int N_SRC = 8  // number of sources
) (
  input wire logic                     clock,
  input wire logic                     rst_n,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [11:0]              paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire logic                     instr_boundary,
  input wire logic                     accept_ack,
  input wire logic                     int_pending,
  input wire logic [$clog2(N_SRC)-1:0] int_source,
  input wire logic [2:0]               int_level,
  input wire logic [N_SRC-1:0]         src_event
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // reset must be seen to work, so this one is never disabled
  a_reset_clears:
    assert property (@(posedge clock) disable iff (1'b0)
      !rst_n |=> !int_pending && int_level == 3'h0)
      else $error("pending not cleared by reset");
  a_rise_at_boundary:
    assert property ($rose(int_pending) |-> $past(instr_boundary))
      else $error("acceptance outside an instruction boundary");
  a_level_nonzero:
    assert property (int_pending |-> int_level != 3'h0)
      else $error("pending with level zero");
  a_hold_until_ack:
    assert property (int_pending && !accept_ack |=>
      int_pending && $stable(int_source) && $stable(int_level))
      else $error("winner changed before acknowledge");
  a_ack_drops:
    assert property (int_pending && accept_ack |=> !int_pending)
      else $error("pending kept after acknowledge");
  a_source_range:
    assert property (int_pending |-> int_source < N_SRC)
      else $error("winner index out of range");
  a_zero_wait:
    assert property (psel && penable |-> pready)
      else $error("access phase not completed at once");
  a_unmapped_err:
    assert property (psel && penable && paddr == 12'hffc |-> pslverr)
      else $error("unmapped access without error");
  a_write_rdata:
    assert property (psel && penable && pwrite |-> prdata == 32'h0)
      else $error("read data not zero on a write");

  // main scenarios reached
  c_accept: cover property ($rose(int_pending));
  c_ack: cover property (int_pending && accept_ack);
  c_err: cover property (pslverr);
endmodule : mia_ctrl_sva

bind mia_ctrl mia_ctrl_sva #(.N_SRC(N_SRC)) u_sva (.clock(clock), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_boundary(instr_boundary),
  .accept_ack(accept_ack), .int_pending(int_pending), .int_source(int_source),
  .int_level(int_level), .src_event(src_event));

// ===== sim/mia_core_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// processor core stand-in
// ----------------------------------------
// two-cycle instructions; acknowledges a pending acceptance after
// ack_wait cycles, so both prompt and slow vector jumps are seen
module mia_core_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [3:0] ack_wait,       // cycles before the jump
  input  wire logic       int_pending,    // acceptance from the block
  output logic            instr_boundary, // new instruction starts
  output logic            accept_ack      // jumped to the vector
);
  logic [3:0] cnt;  // cycles spent pending

  // boundary every other cycle, one-cycle acknowledge pulse
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt            <= 4'h0;
      accept_ack     <= 1'b0;
      instr_boundary <= 1'b0;
    end else begin
      instr_boundary <= ~instr_boundary;
      accept_ack     <= 1'b0;
      // no second pulse while the first is being taken
      if (int_pending && !accept_ack) begin
        if (cnt == ack_wait) begin
          accept_ack <= 1'b1;
          cnt        <= 4'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end else begin
        cnt <= 4'h0;
      end
    end
  end
endmodule : mia_core_model

// ===== sim/maskable_interrupt_acceptance_tb_top.sv
`timescale 1ns/100ps
// ----------------------------------------
// bench for the acceptance block
// ----------------------------------------
module maskable_interrupt_acceptance_tb_top;
  typedef struct packed {
    logic       g;  // gate after enable
    logic [2:0] t;  // threshold
    logic [2:0] l;  // source level
    logic       e;  // accepted
  } mia_row_t;
  logic                  clock = 1'b0;
  logic                  rst_n = 1'b0;
  mia_pkg::mia_apb_req_t req   = '0;     // bus request carrier
  logic [31:0]           prdata;
  logic                  pready, pslverr, instr_boundary, accept_ack, int_pending;
  logic [2:0]            int_source, int_level;
  logic [7:0]            src_event = 8'h00;
  logic [3:0]            ack_wait  = 4'h0;
  int                    err_count = 0;
  int                    samples_checked = 0;
  logic [31:0]           q;
  logic                  e, seen;
  logic [2:0]            s_src, s_lvl;   // winner captured at acceptance
  // gate, threshold, level, expected acceptance
  mia_row_t rows [8] = '{'{1'b1, 3'h0, 3'h1, 1'b1}, '{1'b1, 3'h0, 3'h0, 1'b0},
    '{1'b0, 3'h0, 3'h7, 1'b0}, '{1'b1, 3'h6, 3'h7, 1'b1}, '{1'b1, 3'h7, 3'h7, 1'b0},
    '{1'b1, 3'h3, 3'h3, 1'b0}, '{1'b1, 3'h3, 3'h4, 1'b1}, '{1'b1, 3'h2, 3'h5, 1'b1}};
  mia_pkg::mia_op_t tops [4] = '{mia_pkg::OP_RETURN, mia_pkg::OP_POP_CTRL,
    mia_pkg::OP_LOAD_CTRL, mia_pkg::OP_LOAD_THR};
  logic [31:0] pexp [3] = '{32'h3, 32'h1, 32'h2};  // highest, then lowest index

  mia_ctrl #(.N_SRC(8)) uut (.clock(clock), .rst_n(rst_n), .psel(req.psel),
    .penable(req.penable), .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_boundary(instr_boundary),
    .accept_ack(accept_ack), .int_pending(int_pending), .int_source(int_source),
    .int_level(int_level), .src_event(src_event));
  mia_core_model core (.clock(clock), .rst_n(rst_n), .ack_wait(ack_wait),
    .int_pending(int_pending), .instr_boundary(instr_boundary), .accept_ack(accept_ack));

  initial begin
    forever #20 clock = ~clock;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] sv, input logic [31:0] xv);
    samples_checked++;
    if (sv !== xv) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, xv, sv);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge clock);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clock);
    req.penable <= 1'b1;
    // only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  // instruction port write: opcode, new gate, new threshold
  task automatic do_op(input mia_pkg::mia_op_t o, input logic g, input logic [2:0] t);
    apb(1'b1, mia_pkg::ADDR_INSTR, (32'(o) << mia_pkg::OP_LSB) |
        (32'(g) << mia_pkg::GATE_BIT) | (32'(t) << mia_pkg::THR_LSB), q, e);
  endtask : do_op

  function automatic logic [11:0] ca(input int i);
    return mia_pkg::ADDR_CTRL0 + 12'(mia_pkg::CTRL_STRIDE * i);
  endfunction : ca

  // wait for an acceptance, note the winner, then for its withdrawal
  task automatic wait_pend(input int n);
    int k;
    seen = 1'b0;
    for (k = 0; k < n && !seen; k++) begin
      @(posedge clock);
      #1 seen = (int_pending === 1'b1);
    end
    s_src = int_source;
    s_lvl = int_level;
    for (k = 0; k < 40 && int_pending !== 1'b0; k++) begin
      @(posedge clock);
      #1;
    end
    chk("withdrawn", 32'(int_pending), 32'h0);
  endtask : wait_pend

  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    end_sim();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    // acceptance table on source 0, gate off while rewriting control
    foreach (rows[i]) begin
      ack_wait <= i[0] ? 4'h6 : 4'h0;
      do_op(mia_pkg::OP_FLAG_CLEAR, 1'b0, 3'h0);
      apb(1'b1, ca(0), 32'(rows[i].l), q, e);
      do_op(mia_pkg::OP_LOAD_THR, 1'b0, rows[i].t);
      repeat (4) @(posedge clock);
      src_event <= 8'h01;
      @(posedge clock);
      src_event <= 8'h00;
      // a row with the gate off must leave it off
      do_op(mia_pkg::mia_op_t'(rows[i].g ? mia_pkg::OP_FLAG_SET : mia_pkg::OP_FLAG_CLEAR),
            rows[i].g, 3'h0);
      wait_pend(16);
      chk("accept", 32'(seen), 32'(rows[i].e));
      if (seen) chk("level", 32'(s_lvl), 32'(rows[i].l));
      apb(1'b0, ca(0), 32'h0, q, e);
      chk("ctrl0", q, 32'(rows[i].l) | (rows[i].e ? 32'h0 : 32'h8));
      $display("test row %0d done", i);
    end
    // threshold delay per instruction kind, old value then new
    do_op(mia_pkg::OP_LOAD_THR, 1'b0, 3'h1);
    repeat (4) @(posedge clock);
    foreach (tops[j]) begin
      do_op(tops[j], j != 0, 3'(j + 2));
      @(posedge clock);
      apb(1'b0, mia_pkg::ADDR_STATUS, 32'h0, q, e);
      // captured 3 edges after the write: only the return has landed
      chk("thr at 3", 32'(q[6:4]), 32'((j == 0) ? j + 2 : j + 1));
      if (j == 0) chk("gate now", 32'(q[1]), 32'h0);
      repeat (3) @(posedge clock);
      apb(1'b0, mia_pkg::ADDR_STATUS, 32'h0, q, e);
      chk("thr new", 32'(q[6:4]), 32'(j + 2));
    end
    $display("test threshold timing done");
    // three requests at once: level 6 first, then level-5 tie by index
    do_op(mia_pkg::OP_FLAG_CLEAR, 1'b0, 3'h0);
    do_op(mia_pkg::OP_LOAD_THR, 1'b0, 3'h0);
    for (int k = 1; k < 4; k++) apb(1'b1, ca(k), (k == 3) ? 32'h6 : 32'h5, q, e);
    ack_wait <= 4'h2;
    src_event <= 8'h0e;
    @(posedge clock);
    src_event <= 8'h00;
    do_op(mia_pkg::OP_FLAG_SET, 1'b1, 3'h0);
    foreach (pexp[k]) begin
      wait_pend(16);
      chk("winner", 32'(s_src), pexp[k]);
    end
    $display("test priority done");
    // a one written to a request bit is ignored; unmapped access refused
    do_op(mia_pkg::OP_FLAG_CLEAR, 1'b0, 3'h0);
    apb(1'b1, ca(4), 32'hf, q, e);
    apb(1'b0, ca(4), 32'h0, q, e);
    chk("req write one", q, 32'h7);
    apb(1'b0, 12'hffc, 32'h0, q, e);
    chk("unmapped err", 32'(e), 32'h1);
    chk("unmapped data", q, 32'h0);
    $display("test refusal done");
    // reset in mid-run with a request and a threshold standing
    do_op(mia_pkg::OP_POP_CTRL, 1'b0, 3'h5);
    src_event <= 8'h10;
    @(posedge clock);
    src_event <= 8'h00;
    rst_n <= 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, mia_pkg::ADDR_FLAG, 32'h0, q, e);
    chk("flag image", q, 32'h0);
    apb(1'b0, ca(4), 32'h0, q, e);
    chk("ctrl4", q, 32'h0);
    $display("test reset done");
    end_sim();
  end
endmodule : maskable_interrupt_acceptance_tb_top
